// >>> dv/spc_card_model.sv
// card in the socket: accesses, busy time, capability and retest answer
`timescale 1ns/1ps
`default_nettype none
module spc_card_model #(
  parameter logic [3:0] CAPS = 4'h3,
  parameter int DONE_DLY = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench command and controller request
  input wire logic go,
  input wire logic interrogate_req,
  // card status
  output logic card_access,
  output logic socket_idle,
  output logic [3:0] card_caps,
  output logic interrogate_done
);
  logic [2:0] busy_reg;
  logic [7:0] wait_reg;

  // capability is fixed: a 5v and 3.3v card
  assign card_caps = CAPS;
  assign socket_idle = (busy_reg == 3'h0);

  // ==========================================
  // access keeps the socket busy a few cycles; retest answered after a delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_access <= 1'b0;
      busy_reg <= 3'h0;
      wait_reg <= 8'h0;
      interrogate_done <= 1'b0;
    end else begin
      card_access <= go;
      busy_reg <= go ? 3'h4 : busy_reg - 3'(busy_reg != 3'h0);
      interrogate_done <= 1'b0;
      if (interrogate_req && !interrogate_done) begin
        wait_reg <= wait_reg + 8'h1;
        if (wait_reg == 8'(DONE_DLY)) begin
          interrogate_done <= 1'b1;
          wait_reg <= 8'h0;
        end
      end
    end
  end
endmodule // spc_card_model
`default_nettype wire

// >>> dv/spc_regs_props.sv
// concurrent checks on the socket power and clock register block ports
`timescale 1ns/1ps
`default_nettype none
module spc_regs_props #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // card side
  input wire logic CARD_ACCESS,
  input wire logic SOCKET_IDLE,
  // socket controls
  input wire logic ZOOM_PATH_ON,
  input wire logic VCC_5V_ON,
  input wire logic VCC_3V3_ON,
  input wire logic VCC_XV_ON,
  input wire logic VCC_YV_ON,
  input wire logic VPP_12V_ON,
  input wire logic VPP_VCC_ON,
  input wire logic CARD_CLK_EN
);
  // ==========================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  // ==========================================
  // read steps
  sequence s_rd_ctl;
    RD && ADDR == 8'h10;
  endsequence
  // a quiet read: no card access beside it, so set cannot win
  sequence s_rd_pm;
    RD && ADDR == 8'h20 && !CARD_ACCESS;
  endsequence

  property p_ctl_reserved;
    s_rd_ctl |=> RDATA[31:12] == 20'h0 && !RDATA[8] && !RDATA[3];
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits not zero");
  property p_zoom_active;
    s_rd_ctl |=> RDATA[11] == RDATA[9];
  endproperty
  a_zoom_active: assert property (p_zoom_active) else $error("zoom activity differs from enable");
  property p_zoom_path;
    s_rd_ctl |=> RDATA[9] == ZOOM_PATH_ON;
  endproperty
  a_zoom_path: assert property (p_zoom_path) else $error("zoom path differs from enable bit");
  property p_pm_reserved;
    RD && ADDR == 8'h20 |=> (RDATA & 32'hFCFE_FFFE) == 32'h0;
  endproperty
  a_pm_reserved: assert property (p_pm_reserved) else $error("power management reserved bits not zero");
  property p_access_set;
    CARD_ACCESS ##1 (RD && ADDR == 8'h20) |=> RDATA[25];
  endproperty
  a_access_set: assert property (p_access_set) else $error("access flag missing after card access");
  property p_access_clear;
    s_rd_pm ##1 s_rd_pm |=> !RDATA[25];
  endproperty
  a_access_clear: assert property (p_access_clear) else $error("access flag not cleared by read");
  property p_mode_flag;
    RD && ADDR == 8'h20 && !CARD_CLK_EN |=> RDATA[24];
  endproperty
  a_mode_flag: assert property (p_mode_flag) else $error("clock held but mode flag clear");
  // a busy socket must get its full clock back one cycle later
  property p_busy_clock;
    !SOCKET_IDLE |=> CARD_CLK_EN;
  endproperty
  a_busy_clock: assert property (p_busy_clock) else $error("card clock held while socket busy");
  property p_vcc_onehot;
    $onehot0({VCC_5V_ON, VCC_3V3_ON, VCC_XV_ON, VCC_YV_ON});
  endproperty
  a_vcc_onehot: assert property (p_vcc_onehot) else $error("more than one supply level on");
  property p_vpp_needs_vcc;
    VPP_12V_ON || VPP_VCC_ON |-> VCC_5V_ON || VCC_3V3_ON || VCC_XV_ON || VCC_YV_ON;
  endproperty
  a_vpp_needs_vcc: assert property (p_vpp_needs_vcc) else $error("programming voltage without supply");
endmodule // spc_regs_props

bind spc_regs spc_regs_props #(.ADDR_W(ADDR_W)) spc_regs_props_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR),
  .RD(RD), .RDATA(RDATA), .CARD_ACCESS(CARD_ACCESS), .SOCKET_IDLE(SOCKET_IDLE), .ZOOM_PATH_ON(ZOOM_PATH_ON),
  .VCC_5V_ON(VCC_5V_ON), .VCC_3V3_ON(VCC_3V3_ON), .VCC_XV_ON(VCC_XV_ON), .VCC_YV_ON(VCC_YV_ON),
  .VPP_12V_ON(VPP_12V_ON), .VPP_VCC_ON(VPP_VCC_ON), .CARD_CLK_EN(CARD_CLK_EN));
`default_nettype wire

// >>> dv/spc_regs_test.sv
// self-checking bench for the socket power and clock register block
`timescale 1ns/1ps
`default_nettype none
module spc_regs_test;
  typedef struct {logic [31:0] w; logic [6:0] o;} spc_row_s;
  logic clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd_s = 1'b0, host_prep = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic card_access, socket_idle, done, zoom, v5, v33, vx, vy, p12, pv, bad, ireq, clk_en;
  logic [3:0] caps;
  int mismatches = 0, n_checks = 0, cyc = 0, k;
  // outputs {5v, 3.3v, x, y, 12v, vpp=vcc, bad}; card takes 5v and 3.3v
  spc_row_s rows[13] = '{'{32'h20, 7'h40}, '{32'h30, 7'h20}, '{32'h40, 7'h01}, '{32'h50, 7'h01},
    '{32'h10, 7'h01}, '{32'h60, 7'h01}, '{32'h70, 7'h01}, '{32'h31, 7'h24}, '{32'h33, 7'h22},
    '{32'h22, 7'h42}, '{32'h06, 7'h01}, '{32'hFFFF_F3A8, 7'h40}, '{32'h0, 7'h00}};

  always #2.5 clock = ~clock;

  spc_regs spc_regs_i (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd_s),
    .RDATA(rdata), .CARD_ACCESS(card_access), .SOCKET_IDLE(socket_idle), .HOST_CLK_STOP_PREP(host_prep),
    .CARD_CAPS(caps), .INTERROGATE_DONE(done), .ZOOM_PATH_ON(zoom), .VCC_5V_ON(v5), .VCC_3V3_ON(v33),
    .VCC_XV_ON(vx), .VCC_YV_ON(vy), .VPP_12V_ON(p12), .VPP_VCC_ON(pv), .BAD_VOLT_REQ(bad),
    .INTERROGATE_REQ(ireq), .CARD_CLK_EN(clk_en));
  spc_card_model spc_card_model_i (.clk(clock), .rst_n(arst_n), .go(go), .interrogate_req(ireq),
    .card_access(card_access), .socket_idle(socket_idle), .card_caps(caps), .interrogate_done(done));

  // ==========================================
  // bus tasks start 1 ns after an edge, so reads may run back to back
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      conclude;
    end
  end

  // ==========================================
  initial begin
    wait_cyc(20);
    arst_n <= 1'b1;
    wait_cyc(3);
    rd_reg(8'h10, d); chk("ctl reset", 32'h400, d);
    rd_reg(8'h20, d); chk("pm reset", 32'h0, d);
    rd_reg(8'h40, d); chk("unmapped", 32'h0, d);
    wr_reg(8'h30, 32'h1); rd_reg(8'h10, d); chk("std zoom off", 32'h0, d);
    wr_reg(8'h30, 32'h0); rd_reg(8'h10, d); chk("std zoom on", 32'h400, d);
    // voltage requests and readback
    foreach (rows[i]) begin
      wr_reg(8'h10, rows[i].w);
      chk("volt", 32'(rows[i].o), 32'({v5, v33, vx, vy, p12, pv, bad}));
      rd_reg(8'h10, d);
      chk("ctl", {20'h0, rows[i].w[9], 1'b1, rows[i].w[9], 1'b0, rows[i].w[7:4], 1'b0, rows[i].w[2:0]}, d);
      chk("zoom", 32'(rows[i].w[9]), 32'(zoom));
    end
    // access flag set then cleared by back-to-back reads
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    wait_cyc(1);
    rd_reg(8'h20, d); chk("access set", 32'h1, 32'(d[25]));
    rd_reg(8'h20, d); chk("access clr", 32'h0, 32'(d[25]));
    // stop under both policies, then slow under policy 0
    wr_reg(8'h20, 32'h0001_0000); wr_reg(8'h10, 32'h80); wait_cyc(3);
    chk("stop policy1", 32'h0, 32'(clk_en));
    rd_reg(8'h20, d); chk("mode set", 32'h1, 32'(d[24]));
    wr_reg(8'h10, 32'h0); wait_cyc(2);
    chk("run policy0", 32'h1, 32'(clk_en));
    rd_reg(8'h20, d); chk("mode clr", 32'h0, 32'(d[24]));
    host_prep <= 1'b1; wait_cyc(3);
    chk("stop host prep", 32'h0, 32'(clk_en));
    // a card access makes the socket busy: the stopped clock must come back
    go <= 1'b1;
    wait_cyc(1);
    go <= 1'b0;
    wait_cyc(1);
    chk("busy run", 32'h1, 32'(clk_en));
    wr_reg(8'h20, 32'hFFFF_FFFF); wait_cyc(3);
    k = 0;
    repeat (32) begin
      @(posedge clock);
      #1 k += int'(clk_en);
    end
    chk("slow pulses", 32'h2, 32'(k));
    rd_reg(8'h20, d); chk("pm read", 32'h0301_0001, d);
    wr_reg(8'h20, 32'h1); wait_cyc(2);
    chk("gate off", 32'h1, 32'(clk_en));
    host_prep <= 1'b0;
    // forced capability locks control until retest
    wr_reg(8'h10, 32'h30); wr_reg(8'h30, 32'h40);
    wr_reg(8'h10, 32'h20); rd_reg(8'h10, d); chk("locked", 32'h430, d);
    wr_reg(8'h30, 32'h2); chk("retest req", 32'h1, 32'(ireq));
    k = 0;
    while (ireq === 1'b1 && k < 40) begin
      @(posedge clock);
      #1 k++;
    end
    chk("retest done", 32'h0, 32'(ireq));
    wr_reg(8'h10, 32'h20); rd_reg(8'h10, d); chk("unlocked", 32'h420, d);
    conclude;
  end
endmodule // spc_regs_test
`default_nettype wire

// >>> src/spc_cfg.svh
// constants for the socket power and clock register block
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ==========================================
// register offsets (byte addresses)
`define SPC_OFS_SOCKET_CONTROL 8'h10
`define SPC_OFS_SOCKET_PM 8'h20
`define SPC_OFS_SOCKET_AUX 8'h30

// ==========================================
// reset values
`define SPC_RST_SOCKET_CONTROL 32'h0000_0400
`define SPC_RST_SOCKET_PM 32'h0000_0000

// ==========================================
// socket control field positions
`define SPC_CTL_ZV_ACTIVE_BIT 11
`define SPC_CTL_STD_ZOOM_BIT 10
`define SPC_CTL_ZV_ON_BIT 9
`define SPC_CTL_STOP_POLICY_BIT 7
`define SPC_CTL_VCC_LSB 4
`define SPC_CTL_VPP_LSB 0

// ==========================================
// power-management field positions
`define SPC_PM_ACCESS_BIT 25
`define SPC_PM_MODE_BIT 24
`define SPC_PM_GATE_BIT 16
`define SPC_PM_SEL_BIT 0

// ==========================================
// auxiliary register field positions
`define SPC_AUX_STD_DISABLE_BIT 0
`define SPC_AUX_RETEST_BIT 1
`define SPC_AUX_FORCE_LSB 4
`define SPC_AUX_LOCK_BIT 8

// ==========================================
// card clock timing
`define SPC_SLOW_DIVIDE 16
`define SPC_CLOCK_NS 5

`endif

// >>> src/spc_clock_ctl.sv
// card clock stop/slow decision and divide-by-16 enable
`include "spc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spc_clock_ctl
  import spc_pkg::*;
#(
  parameter int DIVIDE = `SPC_SLOW_DIVIDE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic allowed,
  input wire logic slow_sel,
  output logic card_clk_en,
  output logic mode_changed
);
  localparam int CW = $clog2(DIVIDE);
  spc_clk_e state_reg;
  spc_clk_e state_next;
  logic [CW-1:0] div_reg;

  initial begin
    if (DIVIDE < 2) $error("divide must be at least 2");
  end

  // stop or slow while allowed, back to full speed otherwise
  // the select is followed while idle too, so a rewrite of it is not lost
  always_comb begin
    case (state_reg)
      SPC_CLK_RUN: state_next = allowed ? (slow_sel ? SPC_CLK_SLOW : SPC_CLK_STOP) : SPC_CLK_RUN;
      SPC_CLK_STOP: state_next = allowed ? (slow_sel ? SPC_CLK_SLOW : SPC_CLK_STOP) : SPC_CLK_RUN;
      SPC_CLK_SLOW: state_next = allowed ? (slow_sel ? SPC_CLK_SLOW : SPC_CLK_STOP) : SPC_CLK_RUN;
      default: state_next = SPC_CLK_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPC_CLK_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // divider runs only while slowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (state_reg == SPC_CLK_SLOW) begin
      div_reg <= (div_reg == CW'(DIVIDE - 1)) ? '0 : div_reg + 1'b1;
    end else begin
      div_reg <= '0;
    end
  end

  // one pulse per 16 host clocks when slowed
  assign card_clk_en = (state_reg == SPC_CLK_RUN) ||
    (state_reg == SPC_CLK_SLOW && div_reg == '0);
  assign mode_changed = (state_reg != SPC_CLK_RUN);
endmodule // spc_clock_ctl
`default_nettype wire

// >>> src/spc_pkg.sv
// types for the socket power and clock register block
package spc_pkg;
  // supply request codes
  typedef enum logic [2:0] {
    SPC_VCC_OFF = 3'h0,
    SPC_VCC_5V = 3'h2,
    SPC_VCC_3V3 = 3'h3,
    SPC_VCC_XV = 3'h4,
    SPC_VCC_YV = 3'h5
  } spc_vcc_e;

  // programming-voltage request codes
  typedef enum logic [2:0] {
    SPC_VPP_OFF = 3'h0,
    SPC_VPP_12V = 3'h1,
    SPC_VPP_5V = 3'h2,
    SPC_VPP_3V3 = 3'h3,
    SPC_VPP_XV = 3'h4,
    SPC_VPP_YV = 3'h5
  } spc_vpp_e;

  // card clock states; run to stop and run to slow each flip one bit
  typedef enum logic [1:0] {
    SPC_CLK_RUN = 2'h0,
    SPC_CLK_STOP = 2'h1,
    SPC_CLK_SLOW = 2'h2
  } spc_clk_e;
endpackage

// >>> src/spc_regs.sv
// socket control and power-management register block
// Functional notes
// - socket control bits 31-12, 8 and 3 read zero, writes ignored.
// - zoom activity reads 0 when zoom enable clear, 1 when set.
// - standard zoom support reads 1 while standard-zoom-disable is clear.
// - bit 9 enables the zoom path for the socket.
// - policy 0: stop/slow only if idle and host clock preparing to stop.
// - policy 1: stop/slow whenever socket idle.
// - supply field 6-4: 000 off, 010 5V, 011 3.3V, 100 X, 101 Y.
// - vpp field 2-0: 000 off, 001 12V, 010 5V, 011 3.3V, 100, 101.
// - power the socket only at voltages the card accepts.
// - power-management bits 31-26, 23-17, 15-1 read zero.
// - access flag sets on card access, clears on read.
// - clock-mode flag is 1 while card clock frequency changed.
// - stop/slow select acts only while clock-control enable set.
// - select 0 stops the card clock, 1 divides it by 16.
// - forcing a voltage-capability indication disables socket control.
// - voltage-sense retest re-interrogates and re-enables socket control.
//
// The implementer's own choice: strobed register access.
`include "spc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spc_regs
  import spc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SLOW_DIVIDE = `SPC_SLOW_DIVIDE
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // socket status from card side, host clock stop preparation
  input wire logic CARD_ACCESS,
  input wire logic SOCKET_IDLE,
  input wire logic HOST_CLK_STOP_PREP,
  input wire logic [3:0] CARD_CAPS,
  input wire logic INTERROGATE_DONE,
  // socket controls
  output logic ZOOM_PATH_ON,
  output logic VCC_5V_ON,
  output logic VCC_3V3_ON,
  output logic VCC_XV_ON,
  output logic VCC_YV_ON,
  output logic VPP_12V_ON,
  output logic VPP_VCC_ON,
  output logic BAD_VOLT_REQ,
  output logic INTERROGATE_REQ,
  output logic CARD_CLK_EN
);
  // ==========================================
  // reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  initial begin
    if (ADDR_W < 6) $error("address too narrow for the register map");
  end

  // ==========================================
  // decode
  logic sel_ctl;
  logic sel_pm;
  logic sel_aux;

  assign sel_ctl = (ADDR == ADDR_W'(`SPC_OFS_SOCKET_CONTROL));
  assign sel_pm = (ADDR == ADDR_W'(`SPC_OFS_SOCKET_PM));
  assign sel_aux = (ADDR == ADDR_W'(`SPC_OFS_SOCKET_AUX));

  // ==========================================
  // socket control storage
  logic zoom_video_on_reg;
  logic card_clock_stop_policy_reg;
  logic [2:0] supply_voltage_request_reg;
  logic [2:0] program_voltage_request_reg;
  logic ctl_locked_reg;
  logic std_zoom_model_disable_reg;
  logic [3:0] forced_caps_reg;
  logic interrogate_reg;

  // writes ignored while locked by a forced capability
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      zoom_video_on_reg <= 1'b0;
      card_clock_stop_policy_reg <= 1'b0;
      supply_voltage_request_reg <= 3'h0;
      program_voltage_request_reg <= 3'h0;
    end else if (WR && sel_ctl && !ctl_locked_reg) begin
      zoom_video_on_reg <= WDATA[`SPC_CTL_ZV_ON_BIT];
      card_clock_stop_policy_reg <= WDATA[`SPC_CTL_STOP_POLICY_BIT];
      supply_voltage_request_reg <= WDATA[`SPC_CTL_VCC_LSB +: 3];
      program_voltage_request_reg <= WDATA[`SPC_CTL_VPP_LSB +: 3];
    end
  end

  // ==========================================
  // auxiliary register: std-zoom disable, retest, forced caps
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      std_zoom_model_disable_reg <= 1'b0;
      forced_caps_reg <= 4'h0;
    end else if (WR && sel_aux) begin
      std_zoom_model_disable_reg <= WDATA[`SPC_AUX_STD_DISABLE_BIT];
      forced_caps_reg <= WDATA[`SPC_AUX_FORCE_LSB +: 4];
    end
  end

  // lock: force sets it, retest releases it; force wins a tie
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctl_locked_reg <= 1'b0;
    end else if (WR && sel_aux && WDATA[`SPC_AUX_FORCE_LSB +: 4] != 4'h0) begin
      ctl_locked_reg <= 1'b1;
    end else if (WR && sel_aux && WDATA[`SPC_AUX_RETEST_BIT]) begin
      ctl_locked_reg <= 1'b0;
    end
  end

  // retest request held until card side reports done
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      interrogate_reg <= 1'b0;
    end else if (WR && sel_aux && WDATA[`SPC_AUX_RETEST_BIT]) begin
      interrogate_reg <= 1'b1;
    end else if (INTERROGATE_DONE) begin
      interrogate_reg <= 1'b0;
    end
  end

  // ==========================================
  // power-management storage
  logic card_clock_policy_gate_reg;
  logic card_clock_stop_or_slow_reg;
  logic socket_access_seen_reg;
  logic socket_clock_mode_flag;
  logic pm_read;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      card_clock_policy_gate_reg <= 1'b0;
      card_clock_stop_or_slow_reg <= 1'b0;
    end else if (WR && sel_pm) begin
      card_clock_policy_gate_reg <= WDATA[`SPC_PM_GATE_BIT];
      card_clock_stop_or_slow_reg <= WDATA[`SPC_PM_SEL_BIT];
    end
  end

  // access flag: a new access wins over the read clear
  assign pm_read = RD && sel_pm;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      socket_access_seen_reg <= 1'b0;
    end else if (CARD_ACCESS) begin
      socket_access_seen_reg <= 1'b1;
    end else if (pm_read) begin
      socket_access_seen_reg <= 1'b0;
    end
  end

  // ==========================================
  // clock policy
  logic clk_allowed;

  // policy bit picks whether the host clock state matters
  assign clk_allowed = card_clock_policy_gate_reg && SOCKET_IDLE &&
    (card_clock_stop_policy_reg || HOST_CLK_STOP_PREP);

  spc_clock_ctl #(
    .DIVIDE(SLOW_DIVIDE)
  ) u_clk (
    .clk(CLOCK),
    .rst_n(rst_n),
    .allowed(clk_allowed),
    .slow_sel(card_clock_stop_or_slow_reg),
    .card_clk_en(CARD_CLK_EN),
    .mode_changed(socket_clock_mode_flag)
  );

  // ==========================================
  // voltage check; requests only act on acceptable levels
  logic [3:0] eff_caps;

  assign eff_caps = CARD_CAPS | forced_caps_reg;

  spc_volt_check u_volt (
    .vcc_code(supply_voltage_request_reg),
    .vpp_code(program_voltage_request_reg),
    .card_caps(eff_caps),
    .vcc_5v(VCC_5V_ON),
    .vcc_3v3(VCC_3V3_ON),
    .vcc_xv(VCC_XV_ON),
    .vcc_yv(VCC_YV_ON),
    .vpp_12v(VPP_12V_ON),
    .vpp_vcc(VPP_VCC_ON),
    .bad_request(BAD_VOLT_REQ)
  );

  assign ZOOM_PATH_ON = zoom_video_on_reg;
  assign INTERROGATE_REQ = interrogate_reg;

  // ==========================================
  // read data, one cycle after the strobe
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctl) begin
      rd_mux[`SPC_CTL_ZV_ACTIVE_BIT] = zoom_video_on_reg;
      rd_mux[`SPC_CTL_STD_ZOOM_BIT] = !std_zoom_model_disable_reg;
      rd_mux[`SPC_CTL_ZV_ON_BIT] = zoom_video_on_reg;
      rd_mux[`SPC_CTL_STOP_POLICY_BIT] = card_clock_stop_policy_reg;
      rd_mux[`SPC_CTL_VCC_LSB +: 3] = supply_voltage_request_reg;
      rd_mux[`SPC_CTL_VPP_LSB +: 3] = program_voltage_request_reg;
    end else if (sel_pm) begin
      rd_mux[`SPC_PM_ACCESS_BIT] = socket_access_seen_reg;
      rd_mux[`SPC_PM_MODE_BIT] = socket_clock_mode_flag;
      rd_mux[`SPC_PM_GATE_BIT] = card_clock_policy_gate_reg;
      rd_mux[`SPC_PM_SEL_BIT] = card_clock_stop_or_slow_reg;
    end else if (sel_aux) begin
      rd_mux[`SPC_AUX_STD_DISABLE_BIT] = std_zoom_model_disable_reg;
      rd_mux[`SPC_AUX_RETEST_BIT] = interrogate_reg;
      rd_mux[`SPC_AUX_FORCE_LSB +: 4] = forced_caps_reg;
      rd_mux[`SPC_AUX_LOCK_BIT] = ctl_locked_reg;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule // spc_regs
`default_nettype wire

// >>> src/spc_volt_check.sv
// decodes voltage requests and checks them against card capability
`timescale 1ns/1ps
`default_nettype none
module spc_volt_check
  import spc_pkg::*;
(
  // requests
  input wire logic [2:0] vcc_code,
  input wire logic [2:0] vpp_code,
  // card capability: 5v, 3.3v, x.x, y.y
  input wire logic [3:0] card_caps,
  // decoded supply enables
  output logic vcc_5v,
  output logic vcc_3v3,
  output logic vcc_xv,
  output logic vcc_yv,
  output logic vpp_12v,
  output logic vpp_vcc,
  output logic bad_request
);
  logic vcc_ok;
  logic vpp_ok;

  // supply decode; reserved codes give nothing
  always_comb begin
    vcc_ok = 1'b1;
    vcc_5v = 1'b0;
    vcc_3v3 = 1'b0;
    vcc_xv = 1'b0;
    vcc_yv = 1'b0;
    case (vcc_code)
      SPC_VCC_OFF: vcc_ok = 1'b1;
      SPC_VCC_5V: vcc_5v = card_caps[0];
      SPC_VCC_3V3: vcc_3v3 = card_caps[1];
      SPC_VCC_XV: vcc_xv = card_caps[2];
      SPC_VCC_YV: vcc_yv = card_caps[3];
      default: vcc_ok = 1'b0;
    endcase
    if (vcc_code != SPC_VCC_OFF && !(vcc_5v | vcc_3v3 | vcc_xv | vcc_yv)) begin
      vcc_ok = 1'b0;
    end
  end

  // vpp decode; non-12v levels must match vcc, else refused
  always_comb begin
    vpp_ok = 1'b1;
    vpp_12v = 1'b0;
    vpp_vcc = 1'b0;
    case (vpp_code)
      SPC_VPP_OFF: vpp_ok = 1'b1;
      SPC_VPP_12V: vpp_12v = vcc_ok && vcc_code != SPC_VCC_OFF;
      SPC_VPP_5V: vpp_vcc = vcc_5v;
      SPC_VPP_3V3: vpp_vcc = vcc_3v3;
      SPC_VPP_XV: vpp_vcc = vcc_xv;
      SPC_VPP_YV: vpp_vcc = vcc_yv;
      default: vpp_ok = 1'b0;
    endcase
    if (vpp_code != SPC_VPP_OFF && !(vpp_12v | vpp_vcc)) begin
      vpp_ok = 1'b0;
    end
  end

  assign bad_request = !(vcc_ok && vpp_ok);
endmodule // spc_volt_check
`default_nettype wire
